// File: basel_consts.svh
`ifndef BASEL_CONSTS_SVH
`define BASEL_CONSTS_SVH
// command byte layout, seven bits with the top data bit ignored
`define BASEL_CMD_GROUP_LSB 5
`define BASEL_LISTEN_BASE 8'h20
`define BASEL_TALK_BASE 8'h40
`define BASEL_UNLISTEN 7'h3f
`define BASEL_UNTALK 7'h5f
`define BASEL_SDC 7'h04
`define BASEL_GET 7'h08
`define BASEL_GTL 7'h01
`define BASEL_DCL 7'h14
`define BASEL_LLO 7'h11
`define BASEL_SPE 7'h18
`define BASEL_SPD 7'h19
// factory default addresses of the two variants
`define BASEL_DEFAULT_ADDR_A 5'h0c
`define BASEL_DEFAULT_ADDR_B 5'h0d
`define BASEL_MAX_ADDR 5'h1e
// banner hold time after power-up
`define BASEL_BANNER_MS 1000
`define BASEL_CLK_KHZ 10000
`define BASEL_BANNER_CYC (`BASEL_BANNER_MS * `BASEL_CLK_KHZ)
`endif

// File: basel_pkg.sv
package basel_pkg;
   typedef logic [4:0] basel_addr_t;
   typedef logic [7:0] basel_byte_t;
   typedef enum logic [2:0] {
      BASEL_UC_NONE, BASEL_UC_DCL, BASEL_UC_LLO, BASEL_UC_SPE, BASEL_UC_SPD
   } basel_ucmd_t;
   typedef enum logic [2:0] {
      BASEL_AC_NONE, BASEL_AC_SDC, BASEL_AC_GET, BASEL_AC_GTL
   } basel_acmd_t;
endpackage

// File: basel_match_if.sv
`timescale 1ns/10ps
interface basel_match_if;
   import basel_pkg::*;
   logic [6:0] cmd;
   basel_addr_t own_addr;
   logic is_my_listen;
   logic is_my_talk;
   logic is_unlisten;
   logic is_untalk;
   modport decoder (input cmd, input own_addr, output is_my_listen,
      output is_my_talk, output is_unlisten, output is_untalk);
   modport user (output cmd, output own_addr, input is_my_listen,
      input is_my_talk, input is_unlisten, input is_untalk);
endinterface

// File: basel_addr_match.sv
`timescale 1ns/10ps
`include "basel_consts.svh"
module basel_addr_match (
   basel_match_if.decoder m
);
   import basel_pkg::*;
   logic [6:0] listen_code;
   logic [6:0] talk_code;
   // both match codes derive from the one primary address
   assign listen_code = 7'(`BASEL_LISTEN_BASE)
      | {2'h0, m.own_addr};
   assign talk_code = 7'(`BASEL_TALK_BASE) | {2'h0, m.own_addr};
   // compare on seven bits, top data bit is don't care
   assign m.is_my_listen = (m.cmd == listen_code);
   assign m.is_my_talk = (m.cmd == talk_code);
   assign m.is_unlisten = (m.cmd == `BASEL_UNLISTEN);
   assign m.is_untalk = (m.cmd == `BASEL_UNTALK);
endmodule

// File: basel_bus_address_select.sv
`timescale 1ns/10ps
`include "basel_consts.svh"
// How it works
// - addressed commands are ignored until our listen address arrives.
// - data leaves only after our own talk address was received.
// - listen and talk match values come from the one primary address.
// - any switch address from 0 to 30 is a valid own address.
// - switches are read only at power-up; changes need a power cycle.
// - five switches form an unsigned binary value, lowest switch lsb.
// - after power-up the address is shown briefly with an interface tag.
// - factory default address is 12 or 13 depending on variant; reset here always loads 12.
// - driver direction high drives the line, low receives.
// - attention is only ever an input here, never driven.
// - listen address is primary address plus hex 20.
// - universal commands with attention low act without addressing.
// - device commands with attention high only taken while listening.
module basel_bus_address_select #(
   parameter int BANNER_CYC = `BASEL_BANNER_CYC
) (
   // clock and power-up reset
   input wire logic clk,
   input wire logic reset,
   // address switch bank, asynchronous
   input wire logic addr_switch_lsb,
   input wire logic [2:0] addr_switch_mid,
   input wire logic addr_switch_msb,
   // bus lines as received; attention is low-active
   input wire logic atn_n,
   input wire logic [7:0] dio_in,
   input wire logic byte_strobe,
   // data the instrument wants to send
   input wire logic talk_request,
   // results
   output basel_pkg::basel_addr_t own_addr,
   output logic addr_reserved,
   output logic listen_active,
   output logic talk_active,
   output logic dev_cmd_valid,
   output basel_pkg::basel_byte_t dev_cmd_byte,
   output basel_pkg::basel_ucmd_t univ_cmd,
   output basel_pkg::basel_acmd_t addr_cmd,
   output logic dio_dir,
   output logic hs_dir,
   output logic powerup_address_banner
);
   import basel_pkg::*;
   logic [4:0] sw_meta_r, sw_sync_r;
   logic atn_meta_r, atn_sync_r;
   logic [7:0] dio_meta_r, dio_sync_r;
   logic stb_meta_r, stb_sync_r, stb_prev_r;
   logic loaded_r;
   logic [$clog2(BANNER_CYC+1)-1:0] banner_cnt_r;
   logic stb_rise;
   logic banner_done;
   basel_match_if mi ();
   basel_addr_match u_match (.m(mi));
   assign mi.cmd = dio_sync_r[6:0];
   assign mi.own_addr = own_addr;
   assign stb_rise = stb_sync_r & ~stb_prev_r;
   // banner counter has reached its hold time
   assign banner_done = (banner_cnt_r == BANNER_CYC[$bits(banner_cnt_r)-1:0]);

   // two-stage synchronisers for the switch, attention, data and strobe inputs
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sw_meta_r <= 5'h00;
         sw_sync_r <= 5'h00;
         atn_meta_r <= 1'h1;
         atn_sync_r <= 1'h1;
         dio_meta_r <= 8'h00;
         dio_sync_r <= 8'h00;
         stb_meta_r <= 1'h0;
         stb_sync_r <= 1'h0;
         stb_prev_r <= 1'h0;
      end else begin
         sw_meta_r <= {addr_switch_msb, addr_switch_mid,
            addr_switch_lsb};
         sw_sync_r <= sw_meta_r;
         atn_meta_r <= atn_n;
         atn_sync_r <= atn_meta_r;
         dio_meta_r <= dio_in;
         dio_sync_r <= dio_meta_r;
         stb_meta_r <= byte_strobe;
         stb_sync_r <= stb_meta_r;
         stb_prev_r <= stb_sync_r;
      end
   end

   // capture the switches once, after the synchroniser has filled
   logic [1:0] settle_r;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         settle_r <= 2'h0;
         loaded_r <= 1'h0;
         own_addr <= `BASEL_DEFAULT_ADDR_A;
         addr_reserved <= 1'h0;
      end else if (!loaded_r) begin
         if (settle_r != 2'h3) begin
            settle_r <= settle_r + 2'h1;
         end else begin
            loaded_r <= 1'h1;
            own_addr <= sw_sync_r;
            addr_reserved <= (sw_sync_r > `BASEL_MAX_ADDR);
         end
      end
   end

   // banner shows the address for a while after power-up
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         banner_cnt_r <= '0;
         powerup_address_banner <= 1'h0;
      end else if (loaded_r && !banner_done) begin
         banner_cnt_r <= banner_cnt_r + 1'b1;
         powerup_address_banner <= 1'h1;
      end else begin
         powerup_address_banner <= 1'h0;
      end
   end

   // listen and talk state from command bytes under attention
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         listen_active <= 1'h0;
         talk_active <= 1'h0;
      end else if (loaded_r && stb_rise && !atn_sync_r) begin
         if (mi.is_my_listen) begin
            listen_active <= 1'h1;
         end else if (mi.is_unlisten) begin
            listen_active <= 1'h0;
         end
         if (mi.is_my_talk) begin
            talk_active <= 1'h1;
         end else if (mi.is_untalk || dio_sync_r[6:5] == 2'h2) begin
            talk_active <= 1'h0; // another talker takes over
         end
      end
   end

   // universal and addressed command decode
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         univ_cmd <= BASEL_UC_NONE;
         addr_cmd <= BASEL_AC_NONE;
      end else begin
         univ_cmd <= BASEL_UC_NONE;
         addr_cmd <= BASEL_AC_NONE;
         if (loaded_r && stb_rise && !atn_sync_r) begin
            case (dio_sync_r[6:0])
               `BASEL_DCL: univ_cmd <= BASEL_UC_DCL;
               `BASEL_LLO: univ_cmd <= BASEL_UC_LLO;
               `BASEL_SPE: univ_cmd <= BASEL_UC_SPE;
               `BASEL_SPD: univ_cmd <= BASEL_UC_SPD;
               `BASEL_SDC: if (listen_active) begin
                  addr_cmd <= BASEL_AC_SDC;
               end
               `BASEL_GET: if (listen_active) begin
                  addr_cmd <= BASEL_AC_GET;
               end
               `BASEL_GTL: if (listen_active) begin
                  addr_cmd <= BASEL_AC_GTL;
               end
               default: ;
            endcase
         end
      end
   end

   // device-dependent bytes under attention high
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dev_cmd_valid <= 1'h0;
         dev_cmd_byte <= 8'h00;
      end else begin
         dev_cmd_valid <= stb_rise && atn_sync_r && listen_active;
         if (stb_rise && atn_sync_r && listen_active) begin
            dev_cmd_byte <= dio_sync_r;
         end
      end
   end

   // line driver direction: drive only when talking and attention high
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dio_dir <= 1'h0;
         hs_dir <= 1'h0;
      end else begin
         dio_dir <= talk_active && atn_sync_r
            && talk_request;
         hs_dir <= talk_active && atn_sync_r;
      end
   end

   // command byte taken under attention once the switches are loaded
   sequence cmd_taken;
      loaded_r && stb_rise && !atn_sync_r;
   endsequence

   // address hold, addressing, command gating, banner and driver direction; attention is
   // never an output here, so only the direction outputs are watched
   chk_addr_once: assert property (@(posedge clk)
      disable iff (reset) $past(loaded_r) |-> $stable(own_addr))
      else $error("address changed");
   chk_listen_gate: assert property (@(posedge clk)
      disable iff (reset) addr_cmd != BASEL_AC_NONE |-> $past(listen_active))
      else $error("addressed cmd while not listening");
   chk_talk_gate: assert property (@(posedge clk)
      disable iff (reset) dio_dir |-> $past(talk_active))
      else $error("drive without talk");
   chk_listen_set: assert property (@(posedge clk)
      disable iff (reset) cmd_taken ##0 mi.is_my_listen |=> listen_active)
      else $error("own listen missed");
   chk_talk_set: assert property (@(posedge clk)
      disable iff (reset) cmd_taken ##0 mi.is_my_talk |=> talk_active)
      else $error("own talk missed");
   chk_listen_code: assert property (@(posedge clk)
      disable iff (reset)
      mi.is_my_listen |-> dio_sync_r[6:0] == {2'h1, own_addr})
      else $error("listen code wrong");
   chk_dev_gate: assert property (@(posedge clk)
      disable iff (reset)
      dev_cmd_valid |-> $past(atn_sync_r) && $past(listen_active))
      else $error("device byte taken wrongly");
   chk_univ_free: assert property (@(posedge clk)
      disable iff (reset)
      cmd_taken ##0 dio_sync_r[6:0] == `BASEL_DCL
      |=> univ_cmd == BASEL_UC_DCL)
      else $error("universal missed");
   chk_banner_on: assert property (@(posedge clk)
      disable iff (reset) $rose(loaded_r) |=> powerup_address_banner)
      else $error("no banner");
   chk_dir_atn: assert property (@(posedge clk)
      disable iff (reset) !$past(atn_sync_r) |-> !dio_dir && !hs_dir)
      else $error("drive under attention");
endmodule

// File: basel_ctrl_model.sv
`timescale 1ns/10ps
// bus controller stand-in: attention, data and strobe toward the device
module basel_ctrl_model (
   // reference clock
   input wire logic clk,
   // bus lines
   output logic atn_n,
   output logic [7:0] dio_in,
   output logic byte_strobe
);
   // idle bus, attention high
   initial begin
      atn_n = 1'b1;
      dio_in = 8'hff;
      byte_strobe = 1'b0;
   end
   // one byte: data set up, strobe held, data held, then released
   task automatic send(input logic atn, input logic [7:0] b);
      @(posedge clk);
      #1;
      atn_n = ~atn;
      dio_in = b;
      repeat (2) @(posedge clk);
      #1;
      byte_strobe = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      byte_strobe = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      dio_in = ~b; // released lines stop showing the byte
      repeat (2) @(posedge clk);
      #1; // hand back off the edge so callers never race the clock
   endtask
endmodule

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import basel_pkg::*;
   logic clk, reset, talk_req, atn_n, stb, dv, lst, tlk, rsv, ddir, hdir;
   logic ban;
   logic [4:0] sw;
   logic [7:0] dio;
   basel_addr_t own;
   basel_byte_t dbyte;
   basel_ucmd_t uc;
   basel_acmd_t ac;
   logic dv_seen = 1'b0;
   logic [7:0] dv_b = 8'h00;
   logic [7:0] uc_s = 8'h00;
   logic [7:0] ac_s = 8'h00;
   int error_cnt = 0;
   int n_checks = 0;
   basel_bus_address_select #(.BANNER_CYC(20)) dut_u (.clk(clk),
      .reset(reset), .addr_switch_lsb(sw[0]), .addr_switch_mid(sw[3:1]),
      .addr_switch_msb(sw[4]), .atn_n(atn_n), .dio_in(dio),
      .byte_strobe(stb), .talk_request(talk_req), .own_addr(own),
      .addr_reserved(rsv), .listen_active(lst), .talk_active(tlk),
      .dev_cmd_valid(dv), .dev_cmd_byte(dbyte), .univ_cmd(uc),
      .addr_cmd(ac), .dio_dir(ddir), .hs_dir(hdir),
      .powerup_address_banner(ban));
   basel_ctrl_model ctrl_u (.clk(clk), .atn_n(atn_n), .dio_in(dio),
      .byte_strobe(stb));
   // clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // catch one-cycle command pulses
   always @(posedge clk) begin
      if (dv === 1'b1) begin
         dv_seen <= 1'b1;
         dv_b <= dbyte;
      end
      if (uc !== BASEL_UC_NONE) uc_s <= 8'(uc);
      if (ac !== BASEL_AC_NONE) ac_s <= 8'(ac);
   end
   task automatic check(input string n, input logic [7:0] s, e);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // send a byte with flags cleared, then compare the caught pulses
   task automatic xfer(input logic a, input logic [7:0] b, eu, ea);
      dv_seen = 1'b0;
      uc_s = 8'h00;
      ac_s = 8'h00;
      ctrl_u.send(a, b);
      check("univ_cmd", uc_s, eu);
      check("addr_cmd", ac_s, ea);
   endtask
   // power cycle with switches a, then move switches
   task automatic powerup(input logic [4:0] a);
      int i;
      @(posedge clk);
      #1;
      sw = a;
      reset = 1'b1;
      repeat (16) @(posedge clk);
      #1;
      check("own_addr reset", 8'(own), 8'h0c);
      reset = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      check("banner on", 8'(ban), 8'h01);
      check("own_addr", 8'(own), 8'(a));
      check("reserved", 8'(rsv), 8'(a == 5'h1f));
      sw = ~a;
      for (i = 0; i < 60 && ban !== 1'b0; i++) @(posedge clk);
      check("banner off", 8'(ban), 8'h00);
      check("own_addr held", 8'(own), 8'(a));
      $display("test powerup %h done", a);
   endtask
   // addressing, commands and driver direction for address a
   task automatic run_bus(input logic [4:0] a);
      logic [7:0] la, ta;
      la = 8'h20 + 8'(a);
      ta = 8'h40 + 8'(a);
      xfer(1'b1, 8'h04, 8'h00, 8'h00);
      xfer(1'b0, 8'h46, 8'h00, 8'h00);
      check("data refused", 8'(dv_seen), 8'h00);
      xfer(1'b1, la ^ 8'h01, 8'h00, 8'h00);
      check("listen other", 8'(lst), 8'h00);
      xfer(1'b1, la, 8'h00, 8'h00);
      check("listen", 8'(lst), 8'h01);
      xfer(1'b1, 8'h04, 8'h00, 8'(BASEL_AC_SDC));
      xfer(1'b1, 8'h08, 8'h00, 8'(BASEL_AC_GET));
      xfer(1'b1, 8'h01, 8'h00, 8'(BASEL_AC_GTL));
      xfer(1'b0, 8'h46, 8'h00, 8'h00);
      check("data valid", 8'(dv_seen), 8'h01);
      check("data byte", dv_b, 8'h46);
      xfer(1'b1, 8'h3f, 8'h00, 8'h00);
      check("unlisten", 8'(lst), 8'h00);
      xfer(1'b1, 8'h14, 8'(BASEL_UC_DCL), 8'h00);
      xfer(1'b1, 8'h11, 8'(BASEL_UC_LLO), 8'h00);
      xfer(1'b1, 8'h18, 8'(BASEL_UC_SPE), 8'h00);
      xfer(1'b1, 8'h19, 8'(BASEL_UC_SPD), 8'h00);
      talk_req = 1'b1;
      xfer(1'b0, 8'h30, 8'h00, 8'h00);
      check("dir untalked", 8'({ddir, hdir}), 8'h00);
      xfer(1'b1, ta, 8'h00, 8'h00);
      check("talk", 8'(tlk), 8'h01);
      check("dir atn low", 8'({ddir, hdir}), 8'h00);
      xfer(1'b0, 8'h30, 8'h00, 8'h00);
      check("dir talking", 8'({ddir, hdir}), 8'h03);
      talk_req = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      check("dir no data", 8'({ddir, hdir}), 8'h01);
      xfer(1'b1, 8'h5f, 8'h00, 8'h00);
      check("untalk", 8'({tlk, hdir}), 8'h00);
      $display("test bus %h done", a);
   endtask
   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      $display("[FAIL] run length expected end seen hang");
      print_verdict();
   end
   // main sequence
   initial begin
      reset = 1'b1;
      sw = 5'h0c;
      talk_req = 1'b0;
      powerup(5'h00);
      powerup(5'h1f);
      powerup(5'h0c);
      run_bus(5'h0c);
      powerup(5'h1e);
      run_bus(5'h1e);
      print_verdict();
   end
endmodule
